// file: rtl/tpst_map.svh
// constants for the terminal power-up self-test sequencer
`ifndef TPST_MAP_SVH
`define TPST_MAP_SVH
// led codes: per-test codes held on failure, all-on on pass, off at reset
`define TPST_LED_DISPATCH_ROM_FAIL   8'h10
`define TPST_LED_BANK_FAIL   4'h2
`define TPST_LED_SRAM_FAIL   8'h40
`define TPST_LED_DRAM_FAIL   8'h80
`define TPST_LED_ALL_ON      8'hFF
`define TPST_LED_OFF         8'h00
// per-indicator view bits
`define TPST_IND_CARRIER     8'h01
`define TPST_IND_DISP_AREA   8'h02
`define TPST_IND_INSERT      8'h04
`define TPST_IND_ALL_ON      8'hFF
// screen lines for result text
`define TPST_LINE_TEMP       5'h18
`define TPST_LINE_PERM       5'h19
// bank range, one to ten octal
`define TPST_BANK_FIRST      4'h1
`define TPST_BANK_LAST       4'h8
// short test time in milliseconds
`define TPST_SHORT_MS        10000
`define TPST_CLK_MHZ         200
`endif

// file: rtl/tpst_pkg.sv
// types for the terminal power-up self-test sequencer
package tpst_pkg;
  // result message selector
  typedef enum logic [2:0] {
    TPST_MSG_NONE = 3'h0,
    TPST_MSG_PASS = 3'h1,
    TPST_MSG_ROM  = 3'h2,
    TPST_MSG_RAM  = 3'h3,
    TPST_MSG_DISPATCH_ROM = 3'h4
  } tpst_msg_t;

  // result message to the display generator
  typedef struct packed {
    logic       valid;
    logic [4:0] line;
    tpst_msg_t  msg;
    logic [3:0] bank;
  } tpst_scr_t;

  // one sub-test answer and the bank it is for
  typedef struct packed {
    logic       done;
    logic       fail;
    logic [3:0] bank;
  } tpst_res_t;
endpackage

// file: rtl/tpst_top.sv
// terminal power-up and on-request self-test sequencer
`timescale 1ns/1ps
`include "tpst_map.svh"
// Overview of operation
// - after power-up, enter self-test before normal operation is allowed.
// - shift-lock up at power-up selects long mode until key is pressed.
// - shift-lock pressed switches to short mode, run once, about ten seconds.
// - after short test, leave self-test, home cursor, enable keyboard.
// - escape-sequence request starts the same self-test sequence.
// - dispatch rom, then rom bank, then static ram tests in order.
// - failure led codes 00010000, 0010BBBB with bank, 01000000.
// - stop at first error and hold the failing led indication.
// - control-rom-level failure goes to leds only, not screen.
// - pressing C after such failure shows the error on screen too.
// - per-indicator view lights carrier, bank leds, display area, insert.
// - then dynamic ram test; its failure shows octal 200 on leds.
// - full pass writes pass message on line 24, lights every led.
// - failure replaces pass message with rom bank, ram bank or dispatch rom.
// - result text temporary on line 24, permanent on line 25.
module tpst_top (
  // clock and reset
  input  wire logic               I_SYS_CLK,
  input  wire logic               I_RST_N,
  // keyboard
  input  wire logic               I_SHIFT_LOCK,
  input  wire logic               I_KEY_C,
  input  wire logic               I_ESC_SELFTEST,
  // sub-test engines
  output logic [3:0]              O_TEST_START,
  output logic [3:0]              O_TEST_BANK,
  output logic                    O_TEST_SHORT,
  input  wire tpst_pkg::tpst_res_t I_TEST_RES,
  // indicators and display
  output logic [7:0]              O_LED_CODE,
  output logic [7:0]              O_LED_IND,
  output tpst_pkg::tpst_scr_t     O_SCREEN,
  output logic                    O_CURSOR_HOME,
  output logic                    O_KBD_ENABLE,
  output logic                    O_IN_SELFTEST
);
  localparam int unsigned MS_CYC = `TPST_CLK_MHZ * 1000;
  localparam logic [35:0] SHORT_CYC = 36'(`TPST_SHORT_MS * MS_CYC);
  parameter logic [35:0] SHORT_LIMIT = SHORT_CYC;

  typedef enum logic [7:0] {
    ST_DISPATCH_ROM = 8'h01, ST_BANK = 8'h02, ST_SRAM = 8'h04, ST_DRAM = 8'h08,
    ST_PASS = 8'h10, ST_FAIL = 8'h20, ST_HOLD = 8'h40, ST_RUN  = 8'h80
  } tpst_state_t;

  tpst_state_t state_reg;
  logic        long_reg;
  logic [3:0]  bank_reg;
  logic        control_rom_level_fail_reg;
  logic        shown_reg;
  logic [35:0] timer_reg;
  tpst_pkg::tpst_msg_t msg_reg;

  // bank number onto the four status indicators
  function automatic logic [7:0] bank_ind(input logic [3:0] b);
    bank_ind = (b == `TPST_BANK_LAST) ? 8'h80 : {1'b0, b[2:0] + 3'h0, 4'h0};
  endfunction

  // start pulse for the test tied to a state
  function automatic logic [3:0] start_of(input tpst_state_t s);
    case (s)
      ST_DISPATCH_ROM: start_of = 4'h1;
      ST_BANK: start_of = 4'h2;
      ST_SRAM: start_of = 4'h4;
      ST_DRAM: start_of = 4'h8;
      default: start_of = 4'h0;
    endcase
  endfunction

  // sequencer
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg     <= ST_DISPATCH_ROM;
      bank_reg      <= `TPST_BANK_FIRST;
      control_rom_level_fail_reg <= 1'b0;
      msg_reg       <= tpst_pkg::TPST_MSG_NONE;
      long_reg      <= 1'b1;
    end else begin
      case (state_reg)
        ST_DISPATCH_ROM: begin
          if (I_TEST_RES.done) begin
            if (I_TEST_RES.fail) begin
              control_rom_level_fail_reg <= 1'b1;
              msg_reg       <= tpst_pkg::TPST_MSG_DISPATCH_ROM;
              state_reg     <= ST_FAIL;
            end else begin
              state_reg <= ST_BANK;
            end
          end
        end
        ST_BANK: begin
          if (I_TEST_RES.done) begin
            if (I_TEST_RES.fail) begin
              control_rom_level_fail_reg <= 1'b1;
              msg_reg       <= tpst_pkg::TPST_MSG_ROM;
              state_reg     <= ST_FAIL;
            end else if (bank_reg == `TPST_BANK_LAST) begin
              state_reg <= ST_SRAM;
            end else begin
              bank_reg <= bank_reg + 4'h1;
            end
          end
        end
        ST_SRAM: begin
          if (I_TEST_RES.done) begin
            if (I_TEST_RES.fail) begin
              control_rom_level_fail_reg <= 1'b1;
              msg_reg       <= tpst_pkg::TPST_MSG_RAM;
              state_reg     <= ST_FAIL;
            end else begin
              state_reg <= ST_DRAM;
            end
          end
        end
        ST_DRAM: begin
          if (I_TEST_RES.done) begin
            if (I_TEST_RES.fail) begin
              msg_reg   <= tpst_pkg::TPST_MSG_RAM;
              state_reg <= ST_FAIL;
            end else begin
              msg_reg   <= tpst_pkg::TPST_MSG_PASS;
              state_reg <= ST_PASS;
            end
          end
        end
        ST_PASS: begin
          if (!long_reg || I_SHIFT_LOCK) begin
            if (!long_reg) begin
              // lamp check stands until the short run time is used up
              if (timer_reg == SHORT_LIMIT) begin
                state_reg <= ST_RUN;
              end
            end else begin
              long_reg  <= 1'b0;
              bank_reg  <= `TPST_BANK_FIRST;
              state_reg <= ST_DISPATCH_ROM;
            end
          end else begin
            bank_reg  <= `TPST_BANK_FIRST;
            state_reg <= ST_DISPATCH_ROM;
          end
        end
        ST_FAIL: state_reg <= ST_HOLD;
        ST_HOLD: begin
          if (I_ESC_SELFTEST) begin
            control_rom_level_fail_reg <= 1'b0;
            bank_reg      <= `TPST_BANK_FIRST;
            long_reg      <= 1'b0;
            state_reg     <= ST_DISPATCH_ROM;
          end
        end
        ST_RUN: begin
          if (I_ESC_SELFTEST) begin
            control_rom_level_fail_reg <= 1'b0;
            bank_reg      <= `TPST_BANK_FIRST;
            long_reg      <= 1'b0;
            state_reg     <= ST_DISPATCH_ROM;
          end
        end
        default: state_reg <= ST_DISPATCH_ROM;
      endcase
    end
  end

  // short run length; restarts fresh after a held fault
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      timer_reg <= 36'h0;
    end else if (state_reg == ST_RUN || state_reg == ST_HOLD || long_reg) begin
      timer_reg <= 36'h0;
    end else if (timer_reg != SHORT_LIMIT) begin
      timer_reg <= timer_reg + 36'h1;
    end
  end

  // c key releases control-level error to screen
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      shown_reg <= 1'b0;
    end else if (state_reg != ST_HOLD) begin
      shown_reg <= 1'b0;
    end else if (I_KEY_C) begin
      shown_reg <= 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LED_CODE <= `TPST_LED_OFF;
      O_LED_IND  <= `TPST_LED_OFF;
    end else begin
      case (state_reg)
        ST_DISPATCH_ROM: begin
          O_LED_CODE <= `TPST_LED_DISPATCH_ROM_FAIL;
          O_LED_IND  <= `TPST_IND_CARRIER;
        end
        ST_BANK: begin
          O_LED_CODE <= {`TPST_LED_BANK_FAIL, bank_reg};
          O_LED_IND  <= bank_ind(bank_reg);
        end
        ST_SRAM: begin
          O_LED_CODE <= `TPST_LED_SRAM_FAIL;
          O_LED_IND  <= `TPST_IND_DISP_AREA;
        end
        ST_DRAM: begin
          O_LED_CODE <= `TPST_LED_DRAM_FAIL;
          O_LED_IND  <= `TPST_IND_INSERT;
        end
        ST_PASS, ST_RUN: begin
          O_LED_CODE <= `TPST_LED_ALL_ON;
          O_LED_IND  <= `TPST_IND_ALL_ON;
        end
        default: begin
          O_LED_CODE <= O_LED_CODE;
          O_LED_IND  <= O_LED_IND;
        end
      endcase
    end
  end

  // screen result; line 24 first then line 25
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SCREEN <= '0;
    end else begin
      O_SCREEN.bank <= bank_reg;
      O_SCREEN.msg  <= msg_reg;
      if ((state_reg == ST_HOLD && (!control_rom_level_fail_reg || shown_reg)) ||
          state_reg == ST_RUN) begin
        O_SCREEN.valid <= 1'b1;
        O_SCREEN.line  <= (O_SCREEN.valid) ? `TPST_LINE_PERM : `TPST_LINE_TEMP;
      end else if (state_reg == ST_PASS) begin
        O_SCREEN.valid <= 1'b1;
        O_SCREEN.line  <= `TPST_LINE_TEMP;
      end else begin
        O_SCREEN.valid <= 1'b0;
        O_SCREEN.line  <= `TPST_LINE_TEMP;
      end
    end
  end

  // test engine controls and mode outputs
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_TEST_START  <= 4'h0;
      O_TEST_BANK   <= 4'h0;
      O_TEST_SHORT  <= 1'b0;
      O_CURSOR_HOME <= 1'b0;
      O_KBD_ENABLE  <= 1'b0;
      O_IN_SELFTEST <= 1'b1;
    end else begin
      O_TEST_START  <= start_of(state_reg) & ~{4{I_TEST_RES.done}};
      O_TEST_BANK   <= bank_reg;
      O_TEST_SHORT  <= ~long_reg;
      O_CURSOR_HOME <= (state_reg == ST_PASS) && !long_reg && (timer_reg == SHORT_LIMIT);
      O_KBD_ENABLE  <= (state_reg == ST_RUN);
      O_IN_SELFTEST <= (state_reg != ST_RUN);
    end
  end
endmodule

// file: verif/tpst_eng.sv
// sub-test engine model answering the sequencer
`timescale 1ns/1ps
module tpst_eng (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // request and fault setup
  input  wire logic [3:0]    start,
  input  wire logic [3:0]    bank,
  input  wire logic [3:0]    fail_sel,
  input  wire logic [3:0]    fail_bank,
  input  wire logic [7:0]    lat,
  // answer
  output tpst_pkg::tpst_res_t res
);
  logic [7:0] cnt_reg;
  logic [7:0] seen_reg;
  logic       hit;
  // bank test fails only on the chosen bank
  assign hit = |(start & fail_sel & 4'hD) | (start[1] & fail_sel[1] & (bank == fail_bank));
  // one answer per request, lat late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      seen_reg <= 8'h00;
      res <= '0;
    end else begin
      res <= '0;
      if (start == 4'h0) begin
        cnt_reg <= 8'h00;
        seen_reg <= 8'h00;
      end else if ({start, bank} != seen_reg && cnt_reg >= lat) begin
        res <= {1'b1, hit, bank};
        cnt_reg <= 8'h00;
        seen_reg <= {start, bank};
      end else if ({start, bank} != seen_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule

// file: verif/tpst_chk_asserts.sv
// port checks for the self-test sequencer
`timescale 1ns/1ps
module tpst_chk #(
  parameter logic [35:0] SHORT_LIMIT = 36'h064
) (
  input wire logic [3:0]          O_TEST_START,
  input wire logic [3:0]          O_TEST_BANK,
  input wire logic [7:0]          O_LED_CODE,
  input wire logic [7:0]          O_LED_IND,
  input wire tpst_pkg::tpst_scr_t O_SCREEN,
  input wire tpst_pkg::tpst_res_t I_TEST_RES,
  input wire logic                I_SYS_CLK,
  input wire logic                I_RST_N,
  input wire logic                I_KEY_C,
  input wire logic                O_TEST_SHORT,
  input wire logic                O_CURSOR_HOME,
  input wire logic                O_KBD_ENABLE,
  input wire logic                O_IN_SELFTEST
);
  logic [35:0] short_cnt;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // cycles spent in short self-test, saturating at the limit
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      short_cnt <= 36'h0;
    end else if (!O_TEST_SHORT || !O_IN_SELFTEST) begin
      short_cnt <= 36'h0;
    end else if (short_cnt != SHORT_LIMIT) begin
      short_cnt <= short_cnt + 36'h1;
    end
  end
  a_short_len: assert property (O_CURSOR_HOME |-> short_cnt == SHORT_LIMIT)
    else $error("short run ended early");
  a_exit_home: assert property ($fell(O_IN_SELFTEST) |-> $past(O_CURSOR_HOME))
    else $error("left self-test without home");
  a_run_excl: assert property (!(O_KBD_ENABLE && O_IN_SELFTEST))
    else $error("keyboard on during self-test");
  a_one_test: assert property ($onehot0(O_TEST_START))
    else $error("two tests at once");
  a_dispatch_rom_code: assert property (O_TEST_START[0] |-> O_LED_CODE == 8'h10)
    else $error("dispatch led code");
  a_bank_code: assert property (O_TEST_START[1] |-> O_LED_CODE == {4'h2, O_TEST_BANK})
    else $error("bank led code");
  a_sram_code: assert property (O_TEST_START[2] |-> O_LED_CODE == 8'h40)
    else $error("static ram led code");
  a_fail_stop: assert property (I_TEST_RES.done && I_TEST_RES.fail
    |-> ##[2:3] (O_TEST_START == 4'h0)[*3])
    else $error("tests go on after fault");
  a_dram_fail: assert property (O_TEST_START[3] && I_TEST_RES.done && I_TEST_RES.fail
    |-> ##[2:4] O_LED_CODE == 8'h80 && O_LED_IND[2])
    else $error("dynamic ram fault leds");
  a_ctl_quiet: assert property ($rose(O_SCREEN.valid) && O_SCREEN.msg inside
    {tpst_pkg::TPST_MSG_ROM, tpst_pkg::TPST_MSG_DISPATCH_ROM}
    |-> $past(I_KEY_C) || $past(I_KEY_C, 2) || $past(I_KEY_C, 3))
    else $error("control fault on screen");
  a_pass_lamp: assert property ($rose(O_SCREEN.msg == tpst_pkg::TPST_MSG_PASS)
    |-> O_LED_CODE == 8'hFF && O_LED_IND == 8'hFF)
    else $error("lamp check missing");
  a_home_run: assert property ($rose(O_CURSOR_HOME) |=> !O_CURSOR_HOME && O_KBD_ENABLE
    && !O_IN_SELFTEST && O_SCREEN.line == 5'h19)
    else $error("exit to run wrong");
endmodule
bind tpst_top tpst_chk #(.SHORT_LIMIT(SHORT_LIMIT)) u_chk (
  .O_TEST_START  (O_TEST_START),
  .O_TEST_BANK   (O_TEST_BANK),
  .O_LED_CODE    (O_LED_CODE),
  .O_LED_IND     (O_LED_IND),
  .O_SCREEN      (O_SCREEN),
  .I_TEST_RES    (I_TEST_RES),
  .I_SYS_CLK     (I_SYS_CLK),
  .I_RST_N       (I_RST_N),
  .I_KEY_C       (I_KEY_C),
  .O_TEST_SHORT  (O_TEST_SHORT),
  .O_CURSOR_HOME (O_CURSOR_HOME),
  .O_KBD_ENABLE  (O_KBD_ENABLE),
  .O_IN_SELFTEST (O_IN_SELFTEST)
);

// file: verif/testbench.sv
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
module testbench;
  logic I_SYS_CLK, I_RST_N, I_SHIFT_LOCK, I_KEY_C, I_ESC_SELFTEST;
  logic saw_short = 1'b0;
  logic O_TEST_SHORT, O_CURSOR_HOME, O_KBD_ENABLE, O_IN_SELFTEST;
  logic [3:0] O_TEST_START, O_TEST_BANK, fail_sel;
  logic [7:0] O_LED_CODE, O_LED_IND, lat;
  tpst_pkg::tpst_res_t I_TEST_RES;
  tpst_pkg::tpst_scr_t O_SCREEN;
  int miscompares, n_tests, cyc;
  // short count cut down to keep the run brief
  tpst_top #(.SHORT_LIMIT(36'h064)) dut (
    .I_SYS_CLK      (I_SYS_CLK),
    .I_RST_N        (I_RST_N),
    .I_SHIFT_LOCK   (I_SHIFT_LOCK),
    .I_KEY_C        (I_KEY_C),
    .I_ESC_SELFTEST (I_ESC_SELFTEST),
    .O_TEST_START   (O_TEST_START),
    .O_TEST_BANK    (O_TEST_BANK),
    .O_TEST_SHORT   (O_TEST_SHORT),
    .I_TEST_RES     (I_TEST_RES),
    .O_LED_CODE     (O_LED_CODE),
    .O_LED_IND      (O_LED_IND),
    .O_SCREEN       (O_SCREEN),
    .O_CURSOR_HOME  (O_CURSOR_HOME),
    .O_KBD_ENABLE   (O_KBD_ENABLE),
    .O_IN_SELFTEST  (O_IN_SELFTEST)
  );
  tpst_eng eng (.clk(I_SYS_CLK), .rst_n(I_RST_N), .start(O_TEST_START), .bank(O_TEST_BANK),
    .fail_sel(fail_sel), .fail_bank(4'h3), .lat(lat), .res(I_TEST_RES));
  // 200 MHz clock
  initial begin
    I_SYS_CLK = 1'b0;
    forever #2.5 I_SYS_CLK = ~I_SYS_CLK;
  end
  // watchdog and short-mode monitor
  always @(negedge I_SYS_CLK) begin
    cyc++;
    if (O_TEST_SHORT === 1'b1) saw_short = 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for a led code
  task automatic wait_led(input logic [7:0] e);
    int n;
    n = 0;
    while (O_LED_CODE !== e && n < 500) begin
      @(negedge I_SYS_CLK);
      n++;
    end
    chk("led", e, O_LED_CODE);
  endtask
  task automatic esc(input logic [3:0] sel);
    @(posedge I_SYS_CLK) fail_sel <= sel;
    I_ESC_SELFTEST <= 1'b1;
    @(posedge I_SYS_CLK) I_ESC_SELFTEST <= 1'b0;
  endtask
  // long loop repeats, then one short pass into normal run
  task automatic t_powerup();
    logic [7:0] seq [6];
    int n;
    seq = '{8'h10, 8'h21, 8'h28, 8'h40, 8'h80, 8'hFF};
    chk("insel", 8'h01, {7'h0, O_IN_SELFTEST});
    chk("kbd", 8'h00, {7'h0, O_KBD_ENABLE});
    foreach (seq[i]) wait_led(seq[i]);
    chk("ind", 8'hFF, O_LED_IND);
    chk("msg", 8'h01, {5'h0, O_SCREEN.msg});
    chk("line", 8'h18, {3'h0, O_SCREEN.line});
    wait_led(8'h10);
    chk("short", 8'h00, {7'h0, saw_short});
    @(posedge I_SYS_CLK) I_SHIFT_LOCK <= 1'b1;
    n = 0;
    while (O_KBD_ENABLE !== 1'b1 && n < 3000) begin
      @(negedge I_SYS_CLK);
      n++;
    end
    chk("kbd", 8'h01, {7'h0, O_KBD_ENABLE});
    chk("insel", 8'h00, {7'h0, O_IN_SELFTEST});
    chk("short", 8'h01, {7'h0, saw_short});
    chk("line", 8'h19, {3'h0, O_SCREEN.line});
  endtask
  // dynamic ram fault on a slow engine reaches leds and screen
  task automatic t_dram_fail();
    int n;
    lat <= 8'h28;
    esc(4'h8);
    n = 0;
    while (O_SCREEN.msg !== tpst_pkg::TPST_MSG_RAM && n < 2000) begin
      @(negedge I_SYS_CLK);
      n++;
    end
    repeat (3) @(negedge I_SYS_CLK);
    chk("msg", 8'h03, {5'h0, O_SCREEN.msg});
    chk("led", 8'h80, O_LED_CODE);
    chk("ind", 8'h04, O_LED_IND & 8'h04);
    chk("line", 8'h19, {3'h0, O_SCREEN.line});
    lat <= 8'h03;
  endtask
  // control-level faults held on leds until the C key
  task automatic t_ctl_fail();
    logic [7:0] led [3];
    logic [7:0] ind [3];
    logic [3:0] sel [3];
    logic [7:0] smsg [3];
    led = '{8'h10, 8'h23, 8'h40};
    ind = '{8'h01, 8'h30, 8'h02};
    smsg = '{8'h04, 8'h02, 8'h03};
    sel = '{4'h1, 4'h2, 4'h4};
    foreach (sel[i]) begin
      esc(sel[i]);
      wait_led(led[i]);
      repeat (12) @(negedge I_SYS_CLK);
      chk("hold", led[i], O_LED_CODE);
      chk("start", 8'h00, {4'h0, O_TEST_START});
      chk("ind", ind[i], O_LED_IND & ind[i]);
      chk("quiet", 8'h00, {7'h0, O_SCREEN.valid});
      @(posedge I_SYS_CLK) I_KEY_C <= 1'b1;
      repeat (4) @(negedge I_SYS_CLK);
      chk("cmsg", 8'h01, {7'h0, O_SCREEN.valid});
      chk("smsg", smsg[i], {5'h0, O_SCREEN.msg});
      if (i == 1) chk("sbank", 8'h03, {4'h0, O_SCREEN.bank});
      @(posedge I_SYS_CLK) I_KEY_C <= 1'b0;
    end
  endtask
  initial begin
    I_RST_N = 1'b0;
    I_SHIFT_LOCK = 1'b0;
    I_KEY_C = 1'b0;
    I_ESC_SELFTEST = 1'b0;
    fail_sel = 4'h0;
    lat = 8'h03;
    repeat (8) @(posedge I_SYS_CLK);
    I_RST_N <= 1'b1;
    @(negedge I_SYS_CLK);
    t_powerup();
    t_dram_fail();
    t_ctl_fail();
    results();
  end
endmodule
